// file: ept_excitation_timer.sv
// Excitation period timer with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module ept_excitation_timer (
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              hsel,
	input  wire ept_pkg::ept_addr_t haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire ept_pkg::ept_word_t hwdata,
	input  wire logic              hready,
	output var  ept_pkg::ept_word_t hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              zero_cross_in,
	output logic                   excitation_timer_irq,
	output logic                   dma_request,
	output logic                   conversion_trigger,
	output logic                   irq
);
	import ept_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ept_ctrl_s         ctrl,           next_ctrl;
	ept_aphase_s       aphase,         next_aphase;
	ept_cnt_t          match_value,    next_match_value;
	ept_cnt_t          preload_value,  next_preload_value;
	ept_cnt_t          period_cnt,     next_period_cnt;
	ept_cnt_t          latched_period, next_latched_period;
	ept_cnt_t          timer_count_value, next_timer_count_value;
	logic [ST_W-1:0]   irq_status,     next_irq_status;
	logic [ST_W-1:0]   irq_enable,     next_irq_enable;
	logic              zc_meta,        next_zc_meta;
	logic              zc_sync,        next_zc_sync;
	logic              zc_prev,        next_zc_prev;
	logic              match_d,        next_match_d;
	logic              dma_q,          next_dma_q;
	logic              trig_q,         next_trig_q;
	ept_word_t         rdata,          next_rdata;

	logic              crossing;
	logic              match;
	logic              event_pulse;
	logic              wr_en;
	ept_word_t         rd_mux;

	// ------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------
	assign crossing = ctrl.crossing_edge_polarity ?
		(zc_prev & ~zc_sync) : (zc_sync & ~zc_prev);
	assign match = ctrl.timers_run & ctrl.match_function_on
		& (period_cnt == match_value);
	assign event_pulse = ctrl.timers_run
		& (timer_count_value <= CNT_ONE);
	assign wr_en = aphase.valid & aphase.write;

	// Read multiplexer for the address phase
	always_comb begin
		rd_mux = '0;
		if (haddr[7:0] == OFS_CONTROL) begin
			rd_mux[BIT_MATCH_ON]   = ctrl.match_function_on;
			rd_mux[BIT_IRQ_ALLOW]  = ctrl.irq_output_allow;
			rd_mux[BIT_DMA_ALLOW]  = ctrl.dma_request_allow;
			rd_mux[BIT_TRIG_ALLOW] = ctrl.conversion_trigger_allow;
			rd_mux[BIT_EDGE_POL]   = ctrl.crossing_edge_polarity;
			rd_mux[BIT_RUN]        = ctrl.timers_run;
			rd_mux[CNT_W-1:0]      = timer_count_value;
		end else if (haddr[7:0] == OFS_CAP_CMP) begin
			rd_mux = {latched_period, match_value};
		end else if (haddr[7:0] == OFS_PERIOD_PL) begin
			rd_mux = {period_cnt, preload_value};
		end else if (haddr[7:0] == OFS_IRQ_STAT) begin
			rd_mux[ST_W-1:0] = irq_status;
		end else if (haddr[7:0] == OFS_IRQ_EN) begin
			rd_mux[ST_W-1:0] = irq_enable;
		end else begin
			rd_mux = '0;
		end
	end

	// Next-state computation for all registers
	always_comb begin
		next_zc_meta = zero_cross_in;
		next_zc_sync = zc_meta;
		next_zc_prev = zc_sync;

		// Bus address phase and read data
		next_aphase.valid  = hsel & hready & htrans[1];
		next_aphase.write  = hwrite;
		next_aphase.offset = haddr[7:0];
		next_rdata = rdata;
		if (hsel & hready & htrans[1] & ~hwrite) begin
			next_rdata = rd_mux;
		end

		// Software writes in the data phase
		next_ctrl          = ctrl;
		next_match_value   = match_value;
		next_preload_value = preload_value;
		next_irq_enable    = irq_enable;
		next_irq_status    = irq_status;
		if (wr_en && aphase.offset == OFS_CONTROL) begin
			next_ctrl.match_function_on        = hwdata[BIT_MATCH_ON];
			next_ctrl.irq_output_allow         = hwdata[BIT_IRQ_ALLOW];
			next_ctrl.dma_request_allow        = hwdata[BIT_DMA_ALLOW];
			next_ctrl.conversion_trigger_allow = hwdata[BIT_TRIG_ALLOW];
			next_ctrl.crossing_edge_polarity   = hwdata[BIT_EDGE_POL];
			next_ctrl.timers_run               = hwdata[BIT_RUN];
		end else if (wr_en && aphase.offset == OFS_CAP_CMP) begin
			next_match_value = hwdata[CNT_W-1:0];
		end else if (wr_en && aphase.offset == OFS_PERIOD_PL) begin
			next_preload_value = hwdata[CNT_W-1:0];
		end else if (wr_en && aphase.offset == OFS_IRQ_EN) begin
			next_irq_enable = hwdata[ST_W-1:0];
		end else if (wr_en && aphase.offset == OFS_IRQ_CLR) begin
			next_irq_status = irq_status & ~hwdata[ST_W-1:0];
		end
		// Hardware set wins over a clear in the same cycle
		if (match) begin
			next_irq_status[ST_MATCH] = 1'b1;
		end
		if (crossing) begin
			next_irq_status[ST_CROSSING] = 1'b1;
		end
		if (event_pulse) begin
			next_irq_status[ST_EVENT] = 1'b1;
		end

		// Period measurement counter
		if (match) begin
			next_period_cnt = CNT_ZERO;
		end else if (ctrl.timers_run && crossing) begin
			next_period_cnt = CNT_ZERO;
		end else if (ctrl.timers_run) begin
			next_period_cnt = period_cnt + CNT_ONE;
		end else begin
			next_period_cnt = period_cnt;
		end

		// Latched period on crossing or match, else held
		if (crossing || match) begin
			next_latched_period = period_cnt;
		end else begin
			next_latched_period = latched_period;
		end

		// Event timer: down count, reload at one
		if (!ctrl.timers_run) begin
			next_timer_count_value = preload_value;
		end else if (event_pulse) begin
			next_timer_count_value = preload_value;
		end else begin
			next_timer_count_value = timer_count_value - CNT_ONE;
		end

		next_match_d = match;
		next_dma_q   = event_pulse & ctrl.dma_request_allow;
		next_trig_q  = event_pulse & ctrl.conversion_trigger_allow;
	end

	// Register all state
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl              <= '0;
			aphase            <= '0;
			match_value       <= RST_MATCH;
			preload_value     <= RST_PRELOAD;
			period_cnt        <= CNT_ZERO;
			latched_period    <= CNT_ZERO;
			timer_count_value <= RST_PRELOAD;
			irq_status        <= '0;
			irq_enable        <= '0;
			zc_meta           <= 1'b0;
			zc_sync           <= 1'b0;
			zc_prev           <= 1'b0;
			match_d           <= 1'b0;
			dma_q             <= 1'b0;
			trig_q            <= 1'b0;
			rdata             <= '0;
		end else begin
			ctrl              <= next_ctrl;
			aphase            <= next_aphase;
			match_value       <= next_match_value;
			preload_value     <= next_preload_value;
			period_cnt        <= next_period_cnt;
			latched_period    <= next_latched_period;
			timer_count_value <= next_timer_count_value;
			irq_status        <= next_irq_status;
			irq_enable        <= next_irq_enable;
			zc_meta           <= next_zc_meta;
			zc_sync           <= next_zc_sync;
			zc_prev           <= next_zc_prev;
			match_d           <= next_match_d;
			dma_q             <= next_dma_q;
			trig_q            <= next_trig_q;
			rdata             <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hrdata               = rdata;
	assign hreadyout            = 1'b1;  // Zero wait states
	assign hresp                = 1'b0;  // Always OKAY
	assign excitation_timer_irq = match_d & ctrl.irq_output_allow;
	assign dma_request          = dma_q;
	assign conversion_trigger   = trig_q;
	assign irq                  = |(irq_status & irq_enable);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_dma_gate: assert property (
		dma_request |-> $past(event_pulse)
		&& $past(ctrl.dma_request_allow))
		else $error("dma request without allowed event");
	a_trig_gate: assert property (
		event_pulse && ctrl.conversion_trigger_allow
		|=> conversion_trigger)
		else $error("conversion trigger missing");
	a_edge_select: assert property (
		zc_sync && !zc_prev && !ctrl.crossing_edge_polarity
		|-> crossing)
		else $error("rising crossing not detected");
	a_fall_select: assert property (
		zc_prev && !zc_sync && ctrl.crossing_edge_polarity
		|-> crossing)
		else $error("falling crossing not detected");
	a_halted_hold: assert property (
		!ctrl.timers_run && !crossing
		|=> $stable(period_cnt))
		else $error("period counter moved while halted");
	a_event_count: assert property (
		ctrl.timers_run && !event_pulse
		|=> timer_count_value == $past(timer_count_value) - CNT_ONE)
		else $error("event timer did not count down");
	a_halt_load: assert property (
		!ctrl.timers_run
		|=> timer_count_value == $past(preload_value))
		else $error("event timer not preloaded");
	a_cross_capture: assert property (
		crossing
		|=> latched_period == $past(period_cnt))
		else $error("crossing did not latch period");
	a_match_capture: assert property (
		match
		|=> latched_period == $past(period_cnt))
		else $error("match did not latch period");
	a_cap_hold: assert property (
		!crossing && !match
		|=> $stable(latched_period))
		else $error("latched period changed");
	a_match_clear: assert property (
		match
		|=> period_cnt == CNT_ZERO
		&& latched_period == $past(match_value))
		else $error("match did not clear counter");
	a_match_irq: assert property (
		match ##1 ctrl.irq_output_allow
		|-> excitation_timer_irq
		##1 (!excitation_timer_irq || $past(match)))
		else $error("timer interrupt timing wrong");
	a_event_reload: assert property (
		event_pulse
		|=> timer_count_value == $past(preload_value))
		else $error("event timer not reloaded");
	a_irq_gate: assert property (
		!ctrl.irq_output_allow
		|-> !excitation_timer_irq)
		else $error("timer interrupt while not allowed");
	a_match_off: assert property (
		!ctrl.match_function_on
		|-> !match)
		else $error("match while function off");
	a_period_inc: assert property (
		ctrl.timers_run && !crossing && !match
		|=> period_cnt == $past(period_cnt) + CNT_ONE)
		else $error("period counter did not increment");

	c_match: cover property (match ##1 excitation_timer_irq);
	c_crossing: cover property (crossing && ctrl.timers_run);
	c_fall_edge: cover property (crossing && ctrl.crossing_edge_polarity);
	c_dma: cover property (dma_request && conversion_trigger);
	c_irq: cover property (irq);

endmodule : ept_excitation_timer

`default_nettype wire

// file: ept_pkg.sv
// Constants, register map and types for the excitation period timer
package ept_pkg;

	// ------------------------------------------------------------
	// Bus and data widths
	// ------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int CNT_W  = 16;

	typedef logic [DATA_W-1:0] ept_word_t;
	typedef logic [ADDR_W-1:0] ept_addr_t;
	typedef logic [CNT_W-1:0]  ept_cnt_t;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_CAP_CMP   = 8'h04;
	localparam logic [7:0] OFS_PERIOD_PL = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLR   = 8'h14;

	// ------------------------------------------------------------
	// Control register bit positions
	// ------------------------------------------------------------
	localparam int BIT_MATCH_ON   = 21;
	localparam int BIT_IRQ_ALLOW  = 20;
	localparam int BIT_DMA_ALLOW  = 19;
	localparam int BIT_TRIG_ALLOW = 18;
	localparam int BIT_EDGE_POL   = 17;
	localparam int BIT_RUN        = 16;
	localparam int HALF_HI        = 16;

	// ------------------------------------------------------------
	// Status bits (same layout in enable and clear registers)
	// ------------------------------------------------------------
	localparam int ST_MATCH    = 0;
	localparam int ST_CROSSING = 1;
	localparam int ST_EVENT    = 2;
	localparam int ST_W        = 3;

	// ------------------------------------------------------------
	// Reset values and counter constants
	// ------------------------------------------------------------
	localparam ept_cnt_t RST_MATCH   = 16'hFFFF;
	localparam ept_cnt_t RST_PRELOAD = 16'h0002;
	localparam ept_cnt_t CNT_ONE     = 16'h0001;
	localparam ept_cnt_t CNT_ZERO    = 16'h0000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// Control fields written by software
	typedef struct packed {
		logic match_function_on;
		logic irq_output_allow;
		logic dma_request_allow;
		logic conversion_trigger_allow;
		logic crossing_edge_polarity;
		logic timers_run;
	} ept_ctrl_s;

	// Latched AHB address phase
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] offset;
	} ept_aphase_s;

endpackage : ept_pkg

// file: ept_zc_source.sv
// Excitation zero-crossing source for the period timer bench
`timescale 1ns/1ps
`default_nettype none

module ept_zc_source (
	input  wire logic        ref_clk,
	input  wire logic        enable,
	input  wire logic        level_req,
	input  wire logic [15:0] half_cycles,
	output logic             zero_cross
);
	int unsigned cnt = 0;

	initial zero_cross = 1'b0;

	// Square wave while enabled, else holds the requested level
	always @(posedge ref_clk) begin
		if (!enable) begin
			zero_cross <= level_req;
			cnt <= 0;
		end else if (cnt + 1 >= half_cycles) begin
			zero_cross <= ~zero_cross;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : ept_zc_source

`default_nettype wire

// file: ept_excitation_timer_bench.sv
// Self-checking bench for the excitation period timer
`timescale 1ns/1ps
`default_nettype none

module ept_excitation_timer_bench;
	import ept_pkg::*;

	localparam ept_word_t RUN = 32'h1 << BIT_RUN;
	localparam ept_word_t POL = 32'h1 << BIT_EDGE_POL;
	localparam ept_word_t TRG = 32'h1 << BIT_TRIG_ALLOW;
	localparam ept_word_t DMA = 32'h1 << BIT_DMA_ALLOW;
	localparam ept_word_t IRQ = 32'h1 << BIT_IRQ_ALLOW;
	localparam ept_word_t MAT = 32'h1 << BIT_MATCH_ON;

	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic [1:0]  htrans  = 2'h0;
	logic [2:0]  hsize   = 3'h2;
	ept_addr_t   haddr   = '0;
	ept_word_t   hwdata  = '0;
	ept_word_t   hrdata;
	logic        hreadyout, hresp, zc_pin, et_irq, dma_req, trig, irq;
	logic        zc_en   = 1'b0;
	logic        zc_lvl  = 1'b0;
	logic [15:0] zc_half = 16'h0014;
	int          fail_count = 0;
	int          n_checks   = 0;
	int          cycles     = 0;

	ept_excitation_timer u_ept_excitation_timer (.ref_clk(ref_clk),
		.reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .zero_cross_in(zc_pin),
		.excitation_timer_irq(et_irq), .dma_request(dma_req),
		.conversion_trigger(trig), .irq(irq));

	ept_zc_source u_ept_zc_source (.ref_clk(ref_clk), .enable(zc_en),
		.level_req(zc_lvl), .half_cycles(zc_half), .zero_cross(zc_pin));

	// ------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ------------------------------------------------------------
	initial forever #4 ref_clk = ~ref_clk;

	// Cuts a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Single AHB transfer, address phase then data phase
	task automatic ahb(input logic wr, input logic [7:0] ofs,
		input ept_word_t wd, output ept_word_t rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, ofs};
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] ofs, input ept_word_t d);
		ept_word_t unused;
		ahb(1'b1, ofs, d, unused);
	endtask : wr

	task automatic rd(input logic [7:0] ofs, output ept_word_t d);
		ahb(1'b0, ofs, '0, d);
	endtask : rd

	// Counts output pulses over a window of cycles
	task automatic count(input int n, output int nd, output int nt,
		output int ni);
		nd = 0;
		nt = 0;
		ni = 0;
		repeat (n) begin
			@(posedge ref_clk);
			nd += int'(dma_req === 1'b1);
			nt += int'(trig === 1'b1);
			ni += int'(et_irq === 1'b1);
		end
	endtask : count

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		ept_word_t d;
		rd(OFS_CONTROL, d);
		check(d, {16'h0, RST_PRELOAD});
		rd(OFS_CAP_CMP, d);
		check(d, {16'h0, RST_MATCH});
		rd(OFS_PERIOD_PL, d);
		check(d, {16'h0, RST_PRELOAD});
		rd(8'h18, d);
		check({d[31:1], d[0] | hresp}, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_event();
		ept_word_t d, e;
		int nd, nt, ni;
		wr(OFS_PERIOD_PL, 32'h5); // preload kept at two or more
		rd(OFS_CONTROL, d);
		check(d, 32'h5);
		wr(OFS_CONTROL, RUN | DMA | TRG);
		repeat (10) @(posedge ref_clk);
		count(40, nd, nt, ni);
		check({nd[15:0], nt[15:0]}, {16'd8, 16'd8});
		wr(OFS_CONTROL, RUN | TRG);
		repeat (10) @(posedge ref_clk);
		count(40, nd, nt, ni);
		check({nd[15:0], nt[15:0]}, {16'd0, 16'd8});
		wr(OFS_CONTROL, RUN | DMA);
		repeat (10) @(posedge ref_clk);
		count(40, nd, nt, ni);
		check({nd[15:0], nt[15:0]}, {16'd8, 16'd0});
		wr(OFS_CONTROL, DMA | TRG);
		// Let a pulse launched just before the halt go by
		repeat (2) @(posedge ref_clk);
		count(20, nd, nt, ni);
		check(32'(nd + nt), 32'h0);
		rd(OFS_CONTROL, d);
		check(d, DMA | TRG | 32'h5);
		rd(OFS_PERIOD_PL, d);
		rd(OFS_PERIOD_PL, e);
		check(e, d);
		rd(OFS_IRQ_STAT, d);
		check(32'(d[ST_EVENT]), 32'h1);
		$display("test event timer done");
	endtask : t_event

	task automatic t_match();
		ept_word_t d;
		int nd, nt, ni;
		// Held count is far past ten: match it once to clear it
		rd(OFS_PERIOD_PL, d);
		wr(OFS_CAP_CMP, {16'h0, d[31:16]});
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_CONTROL, RUN | MAT | IRQ);
		wr(OFS_CAP_CMP, 32'h0000_000A);
		repeat (30) @(posedge ref_clk);
		count(55, nd, nt, ni);
		check(32'(ni), 32'h5);
		rd(OFS_CAP_CMP, d);
		check(d, 32'h000A_000A);
		check({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_EN, 32'h0);
		rd(OFS_IRQ_STAT, d);
		check({30'h0, d[ST_MATCH], irq}, 32'h2);
		wr(OFS_CONTROL, RUN | MAT);
		repeat (30) @(posedge ref_clk);
		count(55, nd, nt, ni);
		check(32'(ni), 32'h0);
		wr(OFS_CONTROL, RUN | IRQ);
		wr(OFS_IRQ_CLR, 32'h1);
		wr(OFS_IRQ_EN, 32'h1);
		count(100, nd, nt, ni);
		rd(OFS_IRQ_STAT, d);
		check({30'h0, d[ST_MATCH], irq | (ni != 0)}, 32'h0);
		rd(OFS_CAP_CMP, d);
		check(d, 32'h000A_000A);
		$display("test compare match done");
	endtask : t_match

	task automatic t_cross();
		ept_word_t d, p;
		wr(OFS_CONTROL, RUN);
		for (int pol = 0; pol < 2; pol++) begin
			wr(OFS_CONTROL, pol ? RUN | POL : RUN);
			for (int lv = 1; lv >= 0; lv--) begin
				wr(OFS_IRQ_CLR, 32'h2);
				zc_lvl <= lv[0];
				repeat (8) @(posedge ref_clk);
				rd(OFS_IRQ_STAT, d);
				check(32'(d[ST_CROSSING]), 32'(lv[0] ^ pol[0]));
			end
		end
		wr(OFS_CONTROL, RUN);
		zc_en <= 1'b1;
		repeat (200) @(posedge ref_clk);
		rd(OFS_CAP_CMP, p);
		zc_half <= 16'h001E;
		repeat (300) @(posedge ref_clk);
		rd(OFS_CAP_CMP, d);
		check(32'(d[31:16] - p[31:16]), 32'd20);
		zc_en <= 1'b0;
		repeat (20) @(posedge ref_clk);
		rd(OFS_CAP_CMP, p);
		repeat (100) @(posedge ref_clk);
		rd(OFS_CAP_CMP, d);
		check(d, p);
		$display("test zero crossing done");
	endtask : t_cross

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_event();
		t_match();
		t_cross();
		give_verdict();
	end
endmodule : ept_excitation_timer_bench

`default_nettype wire
